// ==== hurf_top.sv ====
// Purpose: host serial port with programmable line rate, Avalon-MM register slave
// Assumes: clk 50 MHz, synchronous active-high sys_rst, serial input synchronous to clk
// Notes: one receive holding register; a character arriving while it is full is lost unless a data read commits in the same cycle
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - exponent zero: bit rate is reference over mantissa plus one
// - exponent nonzero: reference over mantissa plus 33, over two to exponent minus one
// - rate register at 3Bh, exponent bits 7..5, mantissa bits 4..0, read/write
// - rate register resets to 7Ah, giving 115.2 kbit/s
// - writing new exponent or mantissa changes the bit rate
// - character is one start bit, eight data bits, one stop bit
// - no parity bit sent or expected
// - settings FA, EB, DA give 7.2, 9.6 and 14.4 kbit/s
module hurf_top
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial line
  input wire logic uart_rx_in,
  output logic uart_tx_out
);
  import hurf_pkg::*;

  // bus slave state
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [5:0] idx;
  logic commit;
  logic wr_commit;
  logic rd_commit;

  // register state
  logic [7:0] rate_ff;
  logic [7:0] nxt_rate;
  logic [7:0] rx_data_ff;
  logic [7:0] nxt_rx_data;
  logic rx_valid_ff;
  logic nxt_rx_valid;
  logic ferr_ff;
  logic nxt_ferr;
  logic ovrn_ff;
  logic nxt_ovrn;

  // transmitter state
  hurf_line_state_type tx_state_ff;
  hurf_line_state_type nxt_tx_state;
  logic [HURF_DIV_W-1:0] tx_cnt_ff;
  logic [HURF_DIV_W-1:0] nxt_tx_cnt;
  logic [2:0] tx_bit_ff;
  logic [2:0] nxt_tx_bit;
  logic [7:0] tx_shift_ff;
  logic [7:0] nxt_tx_shift;
  logic tx_line_ff;
  logic nxt_tx_line;
  logic tx_load;
  logic tx_step;
  logic tx_busy;

  // shared timing and receiver results
  logic ref_tick;
  logic [HURF_DIV_W-1:0] bit_divisor;
  logic [7:0] rx_byte;
  logic rx_done;
  logic rx_frame_err;

  hurf_rate_gen u_rate_gen
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .rate_exponent(rate_ff[HURF_EXP_MSB:HURF_EXP_LSB]),
    .rate_mantissa(rate_ff[HURF_MANT_MSB:HURF_MANT_LSB]),
    .ref_tick(ref_tick),
    .bit_divisor(bit_divisor)
  );

  hurf_rx u_rx
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ref_tick(ref_tick),
    .bit_divisor(bit_divisor),
    .rx_line(uart_rx_in),
    .rx_byte(rx_byte),
    .rx_done(rx_done),
    .rx_frame_err(rx_frame_err)
  );

  // bus handshake: one wait cycle, then the access commits on the edge
  // where the master sees waitrequest low; read data is ready by then
  always_comb
  begin
    idx = avs_address[HURF_IDX_MSB:HURF_IDX_LSB];
    commit = (avs_read || avs_write) && !wait_ff;
    wr_commit = avs_write && !wait_ff;
    rd_commit = avs_read && !wait_ff;
    nxt_wait = 1'b1;
    if ((avs_read || avs_write) && wait_ff)
      nxt_wait = 1'b0;
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff)
    begin
      nxt_rdata = '0;
      unique case (idx)
        HURF_IDX_RATE:
          nxt_rdata[7:0] = rate_ff;
        HURF_IDX_RXDATA:
          nxt_rdata[7:0] = rx_data_ff;
        HURF_IDX_STATUS:
        begin
          nxt_rdata[HURF_ST_TXBUSY] = tx_busy;
          nxt_rdata[HURF_ST_RXVALID] = rx_valid_ff;
          nxt_rdata[HURF_ST_FERR] = ferr_ff;
          nxt_rdata[HURF_ST_OVRN] = ovrn_ff;
        end
        default:
          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end
    else
    begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // register file; hardware set of a flag wins over a software clear
  always_comb
  begin
    nxt_rate = rate_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_valid = rx_valid_ff;
    nxt_ferr = ferr_ff;
    nxt_ovrn = ovrn_ff;
    if (wr_commit && idx == HURF_IDX_RATE)
      nxt_rate = avs_writedata[7:0];
    // the divisor follows any rate value; rates above 1228.8 kbit/s are the host's to avoid
    if (rd_commit && idx == HURF_IDX_RXDATA)
      nxt_rx_valid = 1'b0;
    if (wr_commit && idx == HURF_IDX_STATUS)
    begin
      if (avs_writedata[HURF_ST_FERR])
        nxt_ferr = 1'b0;
      if (avs_writedata[HURF_ST_OVRN])
        nxt_ovrn = 1'b0;
    end
    if (rx_done)
    begin
      // a full holding register keeps its old byte unless a data read commits in the same cycle
      if (rx_valid_ff && !(rd_commit && idx == HURF_IDX_RXDATA))
        nxt_ovrn = 1'b1;
      else
      begin
        nxt_rx_data = rx_byte;
        nxt_rx_valid = 1'b1;
      end
    end
    if (rx_frame_err)
      nxt_ferr = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rate_ff <= HURF_RATE_RESET;
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      ferr_ff <= 1'b0;
      ovrn_ff <= 1'b0;
    end
    else
    begin
      rate_ff <= nxt_rate;
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      ferr_ff <= nxt_ferr;
      ovrn_ff <= nxt_ovrn;
    end
  end

  // transmitter: writes while busy are dropped, software polls the busy bit
  always_comb
  begin
    tx_busy = (tx_state_ff != HURF_IDLE);
    tx_load = wr_commit && idx == HURF_IDX_TXDATA && !tx_busy;
    tx_step = ref_tick && (tx_cnt_ff >= bit_divisor - HURF_DIV_ONE);
    nxt_tx_state = tx_state_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_line = tx_line_ff;
    if (ref_tick)
      nxt_tx_cnt = tx_step ? HURF_CNT_ZERO : tx_cnt_ff + HURF_DIV_ONE;
    unique case (tx_state_ff)
      HURF_IDLE:
      begin
        nxt_tx_cnt = HURF_CNT_ZERO;
        nxt_tx_line = HURF_LINE_IDLE;
        if (tx_load)
        begin
          nxt_tx_shift = avs_writedata[7:0];
          nxt_tx_line = HURF_START_LEVEL;
          nxt_tx_state = HURF_START;
        end
      end
      HURF_START:
        if (tx_step)
        begin
          nxt_tx_line = tx_shift_ff[0];
          nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          nxt_tx_bit = HURF_BIT_ZERO;
          nxt_tx_state = HURF_DATA;
        end
      HURF_DATA:
        if (tx_step)
        begin
          nxt_tx_bit = tx_bit_ff + HURF_BIT_ONE;
          if (tx_bit_ff == HURF_LAST_BIT)
          begin
            nxt_tx_line = HURF_STOP_LEVEL;
            nxt_tx_state = HURF_STOP;
          end
          else
          begin
            nxt_tx_line = tx_shift_ff[0];
            nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          end
        end
      HURF_STOP:
        if (tx_step)
        begin
          nxt_tx_line = HURF_LINE_IDLE;
          nxt_tx_state = HURF_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_state_ff <= HURF_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_shift_ff <= '0;
      tx_line_ff <= 1'b1;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_shift_ff <= nxt_tx_shift;
      tx_line_ff <= nxt_tx_line;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign uart_tx_out = tx_line_ff;
endmodule // hurf_top
`default_nettype wire

// ==== hurf_pkg.sv ====
// Purpose: shared constants and types of the host serial port rate and framing block
// Assumes: 50 MHz system clock, 27.12 MHz bit-rate reference synthesised from it
// Notes: register indices are word indices; byte address is four times the index
`default_nettype none
package hurf_pkg;
  // register word indices
  localparam logic [5:0] HURF_IDX_RATE = 6'h3B;
  localparam logic [5:0] HURF_IDX_TXDATA = 6'h30;
  localparam logic [5:0] HURF_IDX_RXDATA = 6'h31;
  localparam logic [5:0] HURF_IDX_STATUS = 6'h32;
  localparam int HURF_IDX_LSB = 2;
  localparam int HURF_IDX_MSB = 7;
  // line rate register layout and reset value
  localparam logic [7:0] HURF_RATE_RESET = 8'h7A;
  localparam int HURF_EXP_MSB = 7;
  localparam int HURF_EXP_LSB = 5;
  localparam int HURF_MANT_MSB = 4;
  localparam int HURF_MANT_LSB = 0;
  // status register bit positions
  localparam int HURF_ST_TXBUSY = 0;
  localparam int HURF_ST_RXVALID = 1;
  localparam int HURF_ST_FERR = 2;
  localparam int HURF_ST_OVRN = 3;
  // clock and reference rates in kHz
  localparam int HURF_CLK_KHZ = 50000;
  localparam int HURF_REF_KHZ = 27120;
  localparam int HURF_ACC_W = 17;
  localparam logic [16:0] HURF_ACC_STEP = 17'(HURF_REF_KHZ);
  localparam logic [16:0] HURF_ACC_MOD = 17'(HURF_CLK_KHZ);
  // bit divisor in reference periods
  localparam int HURF_DIV_W = 13;
  localparam logic [12:0] HURF_DIV_LINEAR_OFS = 13'h0001;
  localparam logic [12:0] HURF_DIV_SCALED_OFS = 13'h0021;
  localparam logic [12:0] HURF_DIV_ONE = 13'h0001;
  localparam logic [12:0] HURF_CNT_ZERO = 13'h0000;
  localparam logic [2:0] HURF_EXP_ONE = 3'h1;
  localparam logic [2:0] HURF_EXP_ZERO = 3'h0;
  // character framing
  localparam logic [2:0] HURF_LAST_BIT = 3'h7;
  localparam logic [2:0] HURF_BIT_ZERO = 3'h0;
  localparam logic [2:0] HURF_BIT_ONE = 3'h1;
  localparam logic HURF_LINE_IDLE = 1'b1;
  localparam logic HURF_START_LEVEL = 1'b0;
  localparam logic HURF_STOP_LEVEL = 1'b1;
  typedef enum logic [1:0] {
    HURF_IDLE = 2'b00,
    HURF_START = 2'b01,
    HURF_DATA = 2'b10,
    HURF_STOP = 2'b11
  } hurf_line_state_type;
endpackage
`default_nettype wire

// ==== hurf_rate_gen.sv ====
// Purpose: reference tick synthesis and bit divisor from the line rate setting
// Assumes: clk at 50 MHz
// Notes: the reference tick has jitter of one system clock; average rate is exact
`timescale 1ns/1ns
`default_nettype none
module hurf_rate_gen
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // rate setting
  input wire logic [2:0] rate_exponent,
  input wire logic [4:0] rate_mantissa,
  // timing out
  output logic ref_tick,
  output logic [hurf_pkg::HURF_DIV_W-1:0] bit_divisor
);
  import hurf_pkg::*;
  logic [HURF_ACC_W-1:0] acc_ff;
  logic [HURF_ACC_W-1:0] nxt_acc;
  logic tick_ff;
  logic nxt_tick;
  logic [HURF_DIV_W-1:0] div_ff;
  logic [HURF_DIV_W-1:0] nxt_div;
  logic [HURF_ACC_W-1:0] sum;

  always_comb
  begin
    sum = acc_ff + HURF_ACC_STEP;
    nxt_acc = sum;
    nxt_tick = 1'b0;
    if (sum >= HURF_ACC_MOD)
    begin
      nxt_acc = sum - HURF_ACC_MOD;
      nxt_tick = 1'b1;
    end
    // divisor follows the register every cycle so a new setting takes hold one clock after the register
    if (rate_exponent == HURF_EXP_ZERO)
      nxt_div = HURF_DIV_W'(rate_mantissa) + HURF_DIV_LINEAR_OFS;
    else
      nxt_div = (HURF_DIV_W'(rate_mantissa) + HURF_DIV_SCALED_OFS)
        << (rate_exponent - HURF_EXP_ONE);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
      div_ff <= HURF_DIV_ONE;
    end
    else
    begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
      div_ff <= nxt_div;
    end
  end

  assign ref_tick = tick_ff;
  assign bit_divisor = div_ff;
endmodule // hurf_rate_gen
`default_nettype wire

// ==== hurf_rx.sv ====
// Purpose: serial receiver, one start, eight data, one stop bit, no parity
// Assumes: rx_line synchronous to clk
// Notes: a start pulse shorter than half a bit is dropped as a glitch
`timescale 1ns/1ns
`default_nettype none
module hurf_rx
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // timing
  input wire logic ref_tick,
  input wire logic [hurf_pkg::HURF_DIV_W-1:0] bit_divisor,
  // line
  input wire logic rx_line,
  // character out
  output logic [7:0] rx_byte,
  output logic rx_done,
  output logic rx_frame_err
);
  import hurf_pkg::*;
  hurf_line_state_type state_ff;
  hurf_line_state_type nxt_state;
  logic line_ff;
  logic prev_ff;
  logic [HURF_DIV_W-1:0] cnt_ff;
  logic [HURF_DIV_W-1:0] nxt_cnt;
  logic [2:0] bit_ff;
  logic [2:0] nxt_bit;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic done_ff;
  logic nxt_done;
  logic ferr_ff;
  logic nxt_ferr;
  logic [HURF_DIV_W-1:0] target;
  logic step;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_done = 1'b0;
    nxt_ferr = 1'b0;
    // half a bit to the start centre, then whole bits to each later centre
    target = (state_ff == HURF_START) ? (bit_divisor >> 1) : (bit_divisor - HURF_DIV_ONE);
    step = ref_tick && (cnt_ff >= target);
    if (ref_tick)
      nxt_cnt = step ? HURF_CNT_ZERO : cnt_ff + HURF_DIV_ONE;
    unique case (state_ff)
      HURF_IDLE:
      begin
        nxt_cnt = HURF_CNT_ZERO;
        if (prev_ff == HURF_LINE_IDLE && line_ff == HURF_START_LEVEL)
          nxt_state = HURF_START;
      end
      HURF_START:
        if (step)
        begin
          nxt_bit = HURF_BIT_ZERO;
          nxt_state = (line_ff == HURF_START_LEVEL) ? HURF_DATA : HURF_IDLE;
        end
      HURF_DATA:
        if (step)
        begin
          nxt_shift = {line_ff, shift_ff[7:1]};
          nxt_bit = bit_ff + HURF_BIT_ONE;
          if (bit_ff == HURF_LAST_BIT)
            nxt_state = HURF_STOP;
        end
      HURF_STOP:
        if (step)
        begin
          nxt_state = HURF_IDLE;
          nxt_done = (line_ff == HURF_STOP_LEVEL);
          nxt_ferr = (line_ff != HURF_STOP_LEVEL);
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= HURF_IDLE;
      line_ff <= 1'b1;
      prev_ff <= 1'b1;
      cnt_ff <= '0;
      bit_ff <= '0;
      shift_ff <= '0;
      done_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      line_ff <= rx_line;
      prev_ff <= line_ff;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      done_ff <= nxt_done;
      ferr_ff <= nxt_ferr;
    end
  end

  assign rx_byte = shift_ff;
  assign rx_done = done_ff;
  assign rx_frame_err = ferr_ff;
endmodule // hurf_rx
`default_nettype wire

// ==== hurf_top_unused_note_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== hurf_top_sva.sv ====
// Purpose: port assertions for the host serial port
// Assumes: bound to hurf_top, one clock, synchronous active-high reset
// Notes: the rate register is shadowed from committed bus writes
`timescale 1ns/1ns
`default_nettype none
module hurf_top_sva
  import hurf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // serial line
  input wire logic uart_rx_in,
  input wire logic uart_tx_out
);
  logic [7:0] rate_ff;
  logic [7:0] nxt_rate;
  logic [5:0] idx;
  logic known;
  assign idx = avs_address[7:2];
  assign known = idx inside {HURF_IDX_RATE, HURF_IDX_TXDATA, HURF_IDX_RXDATA, HURF_IDX_STATUS};
  always_comb
  begin
    nxt_rate = rate_ff;
    if (avs_write && !avs_waitrequest && idx == HURF_IDX_RATE)
      nxt_rate = avs_writedata[7:0];
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rate_ff <= HURF_RATE_RESET;
    else
      rate_ff <= nxt_rate;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  wait_cause_a:
    assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("wait low without request");
  rate_read_a:
    assert property (avs_read && !avs_waitrequest && idx == HURF_IDX_RATE
      |-> avs_readdata == {24'h000000, rate_ff})
    else $error("rate readback wrong");
  unmapped_read_a:
    assert property (avs_read && !avs_waitrequest && !known |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  read_upper_a:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  rdata_hold_a:
    assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved");
  start_min_a:
    assert property ($fell(uart_tx_out) |-> !uart_tx_out [*8])
    else $error("low bit too short");
  high_min_a:
    assert property ($rose(uart_tx_out) |-> uart_tx_out [*8])
    else $error("high bit too short");
endmodule // hurf_top_sva
bind hurf_top hurf_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .uart_rx_in(uart_rx_in), .uart_tx_out(uart_tx_out));
`default_nettype wire

// ==== hurf_host_model.sv ====
// Purpose: host-side serial port facing the device
// Assumes: bit length given in clk cycles by the caller
// Notes: frames with a start bit of 1000 cycles or more are timed only, not decoded
`timescale 1ns/1ns
`default_nettype none
module hurf_host_model
(
  // clock
  input wire logic clk,
  // serial lines
  input wire logic dev_tx,
  output logic dev_rx
);
  logic [7:0] got_byte;
  logic got_stop;
  int start_len;
  int got_cnt;
  int n;
  initial
  begin
    dev_rx = 1'b1;
    got_cnt = 0;
  end
  // receiver times the start bit and samples mid-bit from it
  always
  begin : rx_watch
    @(posedge clk);
    if (dev_tx === 1'b0)
    begin
      n = 0;
      while (dev_tx === 1'b0)
      begin
        @(posedge clk);
        n++;
      end
      start_len = n;
      if (n < 1000)
      begin
        repeat (n / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
          got_byte[i] = dev_tx;
          repeat (n) @(posedge clk);
        end
        got_stop = dev_tx;
      end
      got_cnt++;
    end
  end
  // stop level is a caller choice so a bad frame can be commanded
  task automatic send_char(input logic [7:0] b, input int bitc, input logic stop_lvl);
    logic [9:0] frame;
    frame = {stop_lvl, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      dev_rx <= frame[i];
      repeat (bitc) @(posedge clk);
    end
    dev_rx <= 1'b1;
  endtask
endmodule // hurf_host_model
`default_nettype wire

// ==== hurf_top_tb_top.sv ====
// Purpose: self-checking bench for the host serial port
// Assumes: 50 MHz clk, bus answers within 50 cycles
// Notes: bit lengths allow three cycles for reference tick jitter
`timescale 1ns/1ns
`default_nettype none
module hurf_top_tb_top;
  import hurf_pkg::*;
  logic clk;
  logic sys_rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic uart_rx_in;
  logic uart_tx_out;
  int err_total;
  int check_count;
  hurf_top DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .uart_rx_in(uart_rx_in), .uart_tx_out(uart_tx_out));
  hurf_host_model u_host (.clk(clk), .dev_tx(uart_tx_out), .dev_rx(uart_rx_in));
  always #10 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_near(input string what, input int exp, input int got);
    check_count++;
    if (got < exp - 3 || got > exp + 3)
    begin
      err_total++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // bit length in clk cycles from the rate setting
  function automatic int bit_clks(input logic [7:0] r);
    int t;
    t = (r[7:5] == 3'h0) ? r[4:0] + 1 : (r[4:0] + 33) << (r[7:5] - 1);
    return t * HURF_CLK_KHZ / HURF_REF_KHZ;
  endfunction
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check_val("bus_answer", 32'h1, 32'(n < 50));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_val(what, exp, q);
  endtask
  task automatic wait_host(input int c0, input int lim);
    int n;
    n = 0;
    while (u_host.got_cnt == c0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check_val("host_frame", 32'h1, 32'(n < lim));
  endtask
  task automatic t_regs();
    logic [31:0] q;
    rd_chk(8'hEC, 32'h7A, "rate_reset");
    bus(1'b1, 8'hEC, 32'hFFFFFF35, q);
    rd_chk(8'hEC, 32'h35, "rate_rw");
    bus(1'b1, 8'h04, 32'hFF, q);
    rd_chk(8'h04, 32'h0, "unmapped");
  endtask
  task automatic t_tx(input logic [7:0] r, input logic [7:0] b);
    int c0;
    int n;
    logic [31:0] q;
    c0 = u_host.got_cnt;
    bus(1'b1, 8'hEC, {24'h0, r}, q);
    bus(1'b1, 8'hC0, {24'h0, b}, q);
    rd_chk(8'hC8, 32'h1, "tx_busy");
    wait_host(c0, 20 * bit_clks(r));
    check_val("tx_byte", {24'h0, b}, {24'h0, u_host.got_byte});
    check_val("tx_stop", 32'h1, {31'h0, u_host.got_stop});
    check_near("bit_len", bit_clks(r), u_host.start_len);
    n = 0;
    do
    begin
      bus(1'b0, 8'hC8, 32'h0, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 200);
    check_val("tx_done", 32'h0, q);
  endtask
  task automatic t_rx();
    logic [31:0] q;
    bus(1'b1, 8'hEC, 32'h7A, q);
    u_host.send_char(8'h3C, bit_clks(8'h7A), 1'b1);
    rd_chk(8'hC8, 32'h2, "rx_valid");
    rd_chk(8'hC4, 32'h3C, "rx_byte");
    rd_chk(8'hC8, 32'h0, "rx_taken");
    u_host.send_char(8'h81, bit_clks(8'h7A), 1'b0);
    rd_chk(8'hC8, 32'h4, "frame_err");
    bus(1'b1, 8'hC8, 32'h4, q);
    rd_chk(8'hC8, 32'h0, "err_clear");
    // two characters back to back with no read: the second is lost, the first kept
    u_host.send_char(8'h55, bit_clks(8'h7A), 1'b1);
    u_host.send_char(8'h2A, bit_clks(8'h7A), 1'b1);
    rd_chk(8'hC8, 32'hA, "overrun");
    rd_chk(8'hC4, 32'h55, "ovrn_keep");
    bus(1'b1, 8'hC8, 32'h8, q);
    rd_chk(8'hC8, 32'h0, "ovrn_clear");
  endtask
  // slow rates: time the start bit only, then cut the frame short by reset
  task automatic t_slow(input logic [7:0] r);
    int c0;
    logic [31:0] q;
    c0 = u_host.got_cnt;
    bus(1'b1, 8'hEC, {24'h0, r}, q);
    bus(1'b1, 8'hC0, 32'h1, q);
    wait_host(c0, 2 * bit_clks(r));
    check_near("slow_bit", bit_clks(r), u_host.start_len);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(8'hEC, 32'h7A, "rate_rst");
  endtask
  initial
  begin
    #1800000;
    err_total++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tx(8'h7A, 8'hA5);
    t_tx(8'h15, 8'h6B);
    t_tx(8'h1C, 8'hF1);
    t_tx(8'h5A, 8'h0F);
    t_rx();
    t_slow(8'hFA);
    t_slow(8'hEB);
    t_slow(8'hDA);
    end_sim();
  end
endmodule // hurf_top_tb_top
`default_nettype wire
